/* File: src/i2css_pkg.sv */
// Shared constants for the two-wire slave port and its bus master partner
// Notes on behaviour
// - All slave functions, no general call; start/stop interrupts
// - Standard speed timing; 7-bit and 10-bit addressing
// - Nothing works until port enable bit set
// - Four-bit mode field selects five two-wire modes
// - Mode codes 0110, 0111, 1011, 1110, 1111
// - Pins open-drain only while direction bits are inputs
// - Slave overrides pins only when it must drive
// - Matched byte: auto acknowledge, copy shift to buffer
// - Full or overflow: no acknowledge, no load, interrupt
// - Buffer read clears full; overflow cleared by software
// - Wait start, shift eight bits on rising clock
// - Compare shift bits 7..1 at eighth falling edge
// - Match: load, set full, acknowledge, interrupt ninth fall
// - Master sends 11110 A9 A8 0 then low byte
// - Ten-bit address bytes set update flag, hold clock
// - Repeated start read: no update flag set
// - Write address: clear read flag, buffer gets address
// - Interrupt per byte, software clears it
// - Read address: set read flag, acknowledge, hold clock
// - Software loads transmit byte then sets release bit
// - Release bit one frees clock, zero holds it; here writing zero starts no hold, only the ninth fall begins one
// - Master waits for clock high before each pulse
// - Transmit eight bits, data changes on falling edge
// - Master acknowledge latched ninth rise; not-ack resets slave
`default_nettype none
package i2css_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_BUF = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0C;
  localparam logic [7:0] OFS_DIR = 8'h10;
  localparam logic [7:0] OFS_IRQ = 8'h14;
  // ==========================================================
  // Field positions
  localparam int CTL_OVF = 6;
  localparam int CTL_EN = 5;
  localparam int CTL_REL = 4;
  localparam int STA_P = 4;
  localparam int STA_S = 3;
  localparam int STA_RW = 2;
  localparam int STA_UPD = 1;
  localparam int STA_FULL = 0;
  localparam int DIR_SCL = 4;
  localparam int DIR_SDA = 1;
  // ==========================================================
  // Reset values and codes
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] OWN_RST = 8'h00;
  localparam logic [3:0] MODE_S7 = 4'h6;
  localparam logic [3:0] MODE_S10 = 4'h7;
  localparam logic [3:0] MODE_FWM = 4'hB;
  localparam logic [3:0] MODE_S7SP = 4'hE;
  localparam logic [3:0] MODE_S10SP = 4'hF;
  localparam logic [4:0] TEN_HDR = 5'h1E;
  localparam logic [3:0] BIT_LAST = 4'h8;
  // ==========================================================
  // Master commands and timing
  localparam logic [1:0] OP_START = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_STOP = 2'h3;
  localparam int CLK_NS = 20;
  localparam int T_QTR_NS = 2500;
  localparam logic [7:0] QTR_CYC = 8'((T_QTR_NS + CLK_NS - 1) / CLK_NS);
endpackage
`default_nettype wire

/* File: src/i2css_if.sv */
// Two-wire bus carrier joining the slave port and its master
`default_nettype none
interface i2css_if;
  logic m_scl_o, m_scl_oe, m_sda_o, m_sda_oe;
  logic s_scl_o, s_scl_oe, s_sda_o, s_sda_oe;
  logic scl, sda;
  // ==========================================================
  // Wired-and with pull-ups
  assign scl = !(m_scl_oe && !m_scl_o) && !(s_scl_oe && !s_scl_o);
  assign sda = !(m_sda_oe && !m_sda_o) && !(s_sda_oe && !s_sda_o);
  modport dev(input scl, input sda, output s_scl_o, output s_scl_oe, output s_sda_o, output s_sda_oe);
  modport host(input scl, input sda, output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
endinterface
`default_nettype wire

/* File: src/i2css_slave.sv */
// Two-wire slave port with APB register access
`default_nettype none
module i2css_slave (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, never set
  i2css_if.dev bus // Two-wire pins
);
  import i2css_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b100
  } i2css_st_t;

  i2css_st_t state_ff;
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic pready_ff;
  logic [31:0] prdata_ff;
  logic [7:0] ctrl_ff, own_ff, dir_ff, buf_ff, sr_ff;
  logic full_ff, rw_ff, upd_ff, start_ff, stop_ff, irq_ff;
  logic [3:0] cnt_ff;
  logic nine_ff, tx_ff, hi_ok_ff, hi10_ff, ack_oe_ff, tx_oe_ff, hold_ff, pend_ff;
  logic scl_oe_ff, sda_oe_ff;
  logic rise, fall, start_ev, stop_ev, fire, wr, rd;
  logic en, slave_on, ten, sp_irq, full, m7, is_hdr;
  logic hit, rd_dir, upd_hit, to_data, ev8, ev9f, accept;
  logic [31:0] rd_mux;

  // ==========================================================
  // Pin synchronisers and edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  assign rise = scl_s2 && !scl_d;
  assign fall = !scl_s2 && scl_d;
  assign start_ev = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop_ev = scl_s2 && scl_d && !sda_d && sda_s2;

  // Mode decode
  assign en = ctrl_ff[CTL_EN];
  assign slave_on = en && (ctrl_ff[3:0] == MODE_S7 || ctrl_ff[3:0] == MODE_S10 ||
                           ctrl_ff[3:0] == MODE_S7SP || ctrl_ff[3:0] == MODE_S10SP);
  assign ten = ctrl_ff[3:0] == MODE_S10 || ctrl_ff[3:0] == MODE_S10SP;
  assign sp_irq = en && (ctrl_ff[3:0] == MODE_S7SP || ctrl_ff[3:0] == MODE_S10SP ||
                         ctrl_ff[3:0] == MODE_FWM);
  assign full = full_ff || ctrl_ff[CTL_OVF];

  // ==========================================================
  // APB handshake: one wait state, registered answer
  assign fire = psel && penable && pready_ff;
  assign wr = fire && pwrite;
  assign rd = fire && !pwrite;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd_mux[7:0] = ctrl_ff;
      OFS_STAT: rd_mux[7:0] = {3'h0, stop_ff, start_ff, rw_ff, upd_ff, full_ff};
      OFS_BUF: rd_mux[7:0] = buf_ff;
      OFS_ADDR: rd_mux[7:0] = own_ff;
      OFS_DIR: rd_mux[7:0] = dir_ff;
      OFS_IRQ: rd_mux[0] = irq_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      if (psel && penable && !pready_ff) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Byte decisions at the eighth falling edge
  assign ev8 = slave_on && fall && cnt_ff == BIT_LAST && state_ff != ST_IDLE;
  assign ev9f = slave_on && fall && nine_ff;
  assign m7 = sr_ff[7:1] == own_ff[7:1];
  assign is_hdr = sr_ff[7:3] == TEN_HDR;

  always_comb begin
    hit = 1'b0;
    rd_dir = 1'b0;
    upd_hit = 1'b0;
    to_data = 1'b0;
    if (state_ff == ST_ADDR) begin
      if (!ten) begin
        hit = m7;
        rd_dir = sr_ff[0];
        to_data = 1'b1;
      end else if (hi_ok_ff) begin
        hit = sr_ff == own_ff;
        upd_hit = 1'b1;
        to_data = 1'b1;
      end else if (sr_ff[0]) begin
        hit = m7 && is_hdr && hi10_ff;
        rd_dir = 1'b1;
        to_data = 1'b1;
      end else begin
        hit = m7 && is_hdr;
        upd_hit = 1'b1;
      end
    end else begin
      hit = !tx_ff;
    end
  end

  assign accept = hit && !full;

  // ==========================================================
  // Serial engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      sr_ff <= 8'h00;
      nine_ff <= 1'b0;
      tx_ff <= 1'b0;
      hi_ok_ff <= 1'b0;
      hi10_ff <= 1'b0;
      ack_oe_ff <= 1'b0;
      tx_oe_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else if (!slave_on) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      nine_ff <= 1'b0;
      tx_ff <= 1'b0;
      hi_ok_ff <= 1'b0;
      hi10_ff <= 1'b0;
      ack_oe_ff <= 1'b0;
      tx_oe_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else if (start_ev) begin
      state_ff <= ST_ADDR;
      cnt_ff <= 4'h0;
      nine_ff <= 1'b0;
      tx_ff <= 1'b0;
      hi_ok_ff <= 1'b0;
      ack_oe_ff <= 1'b0;
      tx_oe_ff <= 1'b0;
    end else if (stop_ev) begin
      state_ff <= ST_IDLE;
      tx_ff <= 1'b0;
      hi10_ff <= 1'b0;
      ack_oe_ff <= 1'b0;
      tx_oe_ff <= 1'b0;
    end else begin
      if (wr && paddr == OFS_BUF) begin
        sr_ff <= pwdata[7:0];
        if (tx_ff) begin
          tx_oe_ff <= !pwdata[7];
        end
      end else if (rise && state_ff != ST_IDLE && cnt_ff < BIT_LAST) begin
        sr_ff <= {sr_ff[6:0], sda_s2};
        cnt_ff <= cnt_ff + 4'h1;
      end
      // Ninth rise: latch the master's acknowledge while transmitting
      if (rise && cnt_ff == BIT_LAST) begin
        cnt_ff <= 4'h0;
        nine_ff <= 1'b1;
        if (tx_ff && sda_s2) begin
          state_ff <= ST_IDLE;
          tx_ff <= 1'b0;
        end
      end
      // Eighth fall: judge the byte
      if (ev8) begin
        pend_ff <= state_ff == ST_DATA || hit;
        tx_oe_ff <= 1'b0;
        ack_oe_ff <= accept;
        if (state_ff == ST_ADDR) begin
          if (!hit) begin
            state_ff <= ST_IDLE;
          end else if (accept) begin
            hi_ok_ff <= upd_hit && !to_data;
            if (upd_hit && to_data) begin
              hi10_ff <= 1'b1;
            end
            if (to_data) begin
              state_ff <= ST_DATA;
              tx_ff <= rd_dir;
            end
          end
        end
      end
      // Transmit bits change on falling edges
      if (fall && tx_ff && cnt_ff != 4'h0 && cnt_ff < BIT_LAST) begin
        tx_oe_ff <= !sr_ff[7];
      end
      if (ev9f) begin
        nine_ff <= 1'b0;
        ack_oe_ff <= 1'b0;
        pend_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control, address, direction and status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
      own_ff <= OWN_RST;
      dir_ff <= DIR_RST;
      buf_ff <= 8'h00;
      full_ff <= 1'b0;
      rw_ff <= 1'b0;
      upd_ff <= 1'b0;
      start_ff <= 1'b0;
      stop_ff <= 1'b0;
      irq_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      // Software side first so that hardware sets win
      if (wr && paddr == OFS_CTRL) begin
        ctrl_ff <= {1'b0, pwdata[6:0]};
        if (pwdata[CTL_REL]) begin
          hold_ff <= 1'b0;
        end
      end
      if (wr && paddr == OFS_ADDR) begin
        own_ff <= pwdata[7:0];
        upd_ff <= 1'b0;
        hold_ff <= 1'b0;
      end
      if (wr && paddr == OFS_DIR) begin
        dir_ff <= pwdata[7:0];
      end
      if (wr && paddr == OFS_BUF) begin
        buf_ff <= pwdata[7:0];
      end
      if (wr && paddr == OFS_IRQ) begin
        irq_ff <= pwdata[0];
      end
      if (rd && paddr == OFS_BUF) begin
        full_ff <= 1'b0;
      end
      // Hardware events
      if (!en) begin
        full_ff <= 1'b0;
        rw_ff <= 1'b0;
        upd_ff <= 1'b0;
        start_ff <= 1'b0;
        stop_ff <= 1'b0;
        hold_ff <= 1'b0;
      end else begin
        if (start_ev) begin
          start_ff <= 1'b1;
          stop_ff <= 1'b0;
          irq_ff <= irq_ff || sp_irq;
        end
        if (stop_ev) begin
          stop_ff <= 1'b1;
          start_ff <= 1'b0;
          hold_ff <= 1'b0;
          irq_ff <= irq_ff || sp_irq;
        end
        if (ev8 && full && state_ff == ST_DATA && !tx_ff) begin
          ctrl_ff[CTL_OVF] <= 1'b1;
        end
        if (ev8 && accept) begin
          buf_ff <= sr_ff;
          full_ff <= 1'b1;
          if (state_ff == ST_ADDR && to_data) begin
            rw_ff <= rd_dir;
          end
          if (upd_hit) begin
            upd_ff <= 1'b1;
          end
        end
        if (rise && cnt_ff == BIT_LAST && tx_ff && sda_s2) begin
          rw_ff <= 1'b0;
          upd_ff <= 1'b0;
          full_ff <= 1'b0;
        end
        if (ev9f && (pend_ff || tx_ff)) begin
          irq_ff <= 1'b1;
        end
        if (ev9f && (upd_ff || tx_ff)) begin
          hold_ff <= 1'b1;
          ctrl_ff[CTL_REL] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Open-drain pin drive, gated by mode and direction bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      scl_oe_ff <= slave_on && dir_ff[DIR_SCL] && hold_ff;
      sda_oe_ff <= slave_on && dir_ff[DIR_SDA] && (ack_oe_ff || tx_oe_ff);
    end
  end

  assign bus.s_scl_oe = scl_oe_ff;
  assign bus.s_sda_oe = sda_oe_ff;
  assign bus.s_scl_o = 1'b0; // Open drain only pulls low
  assign bus.s_sda_o = 1'b0;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = 1'b0;
endmodule
`default_nettype wire

/* File: src/i2css_master.sv */
// Two-wire bus master that drives the slave port from simple commands
`default_nettype none
module i2css_master (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic cmd_valid, // Command offered
  input wire logic [1:0] cmd_op, // Start, write, read or stop
  input wire logic [7:0] cmd_data, // Byte to write
  input wire logic cmd_ack, // Acknowledge a read byte
  output logic cmd_ready, // Ready for a command
  output logic rsp_valid, // Command done pulse
  output logic [7:0] rsp_data, // Byte sampled
  output logic rsp_nack, // Ninth bit was high
  i2css_if.host bus // Two-wire pins
);
  import i2css_pkg::*;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_START = 4'b0010,
    M_BIT = 4'b0100,
    M_STOP = 4'b1000
  } i2css_mst_t;

  i2css_mst_t st_ff;
  logic scl_s1, scl_s2, sda_s1, sda_s2;
  logic [7:0] qcnt_ff;
  logic [1:0] ph_ff;
  logic [3:0] bit_ff;
  logic [8:0] sh_ff, rx_ff;
  logic scl_oe_ff, sda_oe_ff, ready_ff, rsp_ff;
  logic tick, adv;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  // Quarter period timer, stalls while the clock is stretched
  assign tick = qcnt_ff == QTR_CYC - 8'h01;
  assign adv = tick && (ph_ff != 2'h1 || scl_s2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt_ff <= 8'h00;
    end else if (st_ff == M_IDLE || adv) begin
      qcnt_ff <= 8'h00;
    end else if (!tick) begin
      qcnt_ff <= qcnt_ff + 8'h01;
    end
  end

  // ==========================================================
  // Bus sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= M_IDLE;
      ph_ff <= 2'h0;
      bit_ff <= 4'h0;
      sh_ff <= 9'h000;
      rx_ff <= 9'h000;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      ready_ff <= 1'b1;
      rsp_ff <= 1'b0;
    end else begin
      rsp_ff <= 1'b0;
      case (st_ff)
        M_IDLE: begin
          if (cmd_valid && ready_ff) begin
            ready_ff <= 1'b0;
            ph_ff <= 2'h0;
            bit_ff <= 4'h0;
            case (cmd_op)
              OP_START: begin
                st_ff <= M_START;
                sda_oe_ff <= 1'b0;
              end
              OP_STOP: begin
                st_ff <= M_STOP;
                sda_oe_ff <= 1'b1;
              end
              OP_WRITE: begin
                st_ff <= M_BIT;
                sh_ff <= {cmd_data, 1'b1};
                sda_oe_ff <= !cmd_data[7];
              end
              default: begin
                st_ff <= M_BIT;
                sh_ff <= {8'hFF, !cmd_ack};
                sda_oe_ff <= 1'b0;
              end
            endcase
          end
        end
        M_START, M_BIT, M_STOP: begin
          if (adv) begin
            ph_ff <= ph_ff + 2'h1;
            case (ph_ff)
              2'h0: scl_oe_ff <= 1'b0;
              2'h1: begin
                if (st_ff == M_START) begin
                  sda_oe_ff <= 1'b1;
                end
                if (st_ff == M_BIT) begin
                  rx_ff <= {rx_ff[7:0], sda_s2};
                end
              end
              2'h2: begin
                if (st_ff == M_STOP) begin
                  sda_oe_ff <= 1'b0;
                end else begin
                  scl_oe_ff <= 1'b1;
                end
              end
              default: begin
                if (st_ff == M_BIT && bit_ff != BIT_LAST) begin
                  bit_ff <= bit_ff + 4'h1;
                  sh_ff <= {sh_ff[7:0], 1'b1};
                  sda_oe_ff <= !sh_ff[7];
                end else begin
                  st_ff <= M_IDLE;
                  ready_ff <= 1'b1;
                  rsp_ff <= 1'b1;
                  if (st_ff == M_BIT) begin
                    sda_oe_ff <= 1'b0;
                  end
                end
              end
            endcase
          end
        end
        default: st_ff <= M_IDLE;
      endcase
    end
  end

  assign bus.m_scl_oe = scl_oe_ff;
  assign bus.m_sda_oe = sda_oe_ff;
  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  assign cmd_ready = ready_ff;
  assign rsp_valid = rsp_ff;
  assign rsp_data = rx_ff[8:1];
  assign rsp_nack = rx_ff[0];
endmodule
`default_nettype wire

/* File: tb/i2css_properties.sv */
// Wire-level properties between the slave port and its bus master
`default_nettype none
module i2css_properties (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire logic scl, // Clock line
  input wire logic sda, // Data line
  input wire logic m_scl_oe, // Master pulls clock
  input wire logic m_sda_oe, // Master pulls data
  input wire logic s_scl_oe, // Slave pulls clock
  input wire logic s_sda_oe // Slave pulls data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Line checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Lines are the wired-and of both ends
  a_scl_wired_and: assert property (scl == !(m_scl_oe || s_scl_oe))
    else $error("clock line level wrong");
  a_sda_wired_and: assert property (sda == !(m_sda_oe || s_sda_oe))
    else $error("data line level wrong");
  // Ends drive nothing right after reset
  a_idle_after_reset: assert property ($rose(presetn) |-> !s_scl_oe && !s_sda_oe && !m_scl_oe && !m_sda_oe)
    else $error("pin driven after reset");
  // Slave data only moves while the clock is low
  a_slave_data_low: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave data moved with clock high");
  a_slave_data_held: assert property ($rose(scl) |-> $stable(s_sda_oe) [*8])
    else $error("slave data unstable in high time");
  // Stretching starts only in the low phase
  a_stretch_in_low: assert property ($rose(s_scl_oe) |-> !$past(scl))
    else $error("stretch began with clock high");
  // Master pulls the clock only after seeing it high
  a_master_waits: assert property ($rose(m_scl_oe) |-> $past(scl))
    else $error("master pulled clock while held");
  a_high_time: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high time too short");
endmodule
`default_nettype wire

/* File: tb/i2c_slave_serial_port_test.sv */
// Bench joining the two-wire slave port and its bus master
`default_nettype none
module i2c_slave_serial_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import i2css_pkg::*;
  // ==========================================================
  // Signals and instances
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic cmd_valid = 1'b0, cmd_ack = 1'b0, pready, pslverr, cmd_ready, rsp_valid, rsp_nack;
  logic [1:0] cmd_op = 2'h0;
  logic [7:0] paddr = 8'h00, cmd_data = 8'h00, rsp_data;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd_q;
  int failures = 0, checks = 0;
  i2css_if bus_if ();
  i2css_slave i2css_slave_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if.dev));
  i2css_master i2css_master_i (.pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_ack(cmd_ack), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack), .bus(bus_if.host));
  i2css_properties i2css_properties_i (.pclk(pclk), .presetn(presetn), .scl(bus_if.scl), .sda(bus_if.sda),
    .m_scl_oe(bus_if.m_scl_oe), .m_sda_oe(bus_if.m_sda_oe), .s_scl_oe(bus_if.s_scl_oe),
    .s_sda_oe(bus_if.s_sda_oe));
  // Clock of 20 ns
  always #10 pclk = ~pclk;
  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, read data kept in rd_q
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_q = prdata;
    chk("pslverr", {7'h00, pslverr}, 8'h00);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) chk("pready", 8'h00, 8'h01);
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rd_q[7:0] & m, e);
  endtask
  // Hand one command to the master
  task automatic go(input logic [1:0] op, input logic [7:0] d, input logic ak);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    cmd_ack <= ak;
    do begin
      @(posedge pclk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    cmd_valid <= 1'b0;
    @(posedge pclk);
  endtask
  // Wait for the end pulse of a command
  task automatic fin();
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20000) chk("rsp", 8'h00, 8'h01);
  endtask
  task automatic x(input logic [1:0] op);
    go(op, 8'h00, 1'b1);
    fin();
  endtask
  // Write a byte and compare the ninth bit
  task automatic xw(input logic [7:0] d, input logic e);
    go(OP_WRITE, d, 1'b1);
    fin();
    chk("nack", {7'h00, rsp_nack}, {7'h00, e});
  endtask
  // Read one byte the slave holds off until software loads it
  task automatic rdbyte(input logic [7:0] tx, input logic [3:0] md);
    go(OP_READ, 8'h00, 1'b0);
    repeat (400) @(posedge pclk);
    chk("stretch", {7'h00, bus_if.scl}, 8'h00);
    apb(1'b1, OFS_BUF, {24'h00_0000, tx});
    apb(1'b1, OFS_CTRL, {28'h000_0003, md});
    fin();
    chk("tx", rsp_data, tx);
    rc("nack stat", OFS_STAT, 8'h07, 8'h00);
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_off();
    rc("ctrl", OFS_CTRL, 8'hFF, CTRL_RST);
    rc("dir", OFS_DIR, 8'hFF, DIR_RST);
    rc("unmapped", 8'h20, 8'hFF, 8'h00);
    apb(1'b1, OFS_ADDR, 32'h0000_00A4);
    x(OP_START);
    xw(8'hA4, 1'b1);
    x(OP_STOP);
  endtask
  // Every mode reads back; start/stop interrupts only where enabled; firmware master leaves slave idle
  task automatic s_modes();
    logic [3:0] md [5];
    md = '{MODE_S7, MODE_S10, MODE_S7SP, MODE_S10SP, MODE_FWM};
    foreach (md[i]) begin
      apb(1'b1, OFS_CTRL, {28'h000_0003, md[i]});
      rc("mode", OFS_CTRL, 8'hFF, {4'h3, md[i]});
      apb(1'b1, OFS_IRQ, 32'h0000_0000);
      x(OP_START);
      rc("start irq", OFS_IRQ, 8'h01, {7'h00, i >= 2});
      rc("start bit", OFS_STAT, 8'h18, 8'h08);
      if (md[i] == MODE_FWM) xw(8'hA4, 1'b1);
      apb(1'b1, OFS_IRQ, 32'h0000_0000);
      x(OP_STOP);
      rc("stop irq", OFS_IRQ, 8'h01, {7'h00, i >= 2});
      rc("stop bit", OFS_STAT, 8'h18, 8'h10);
    end
  endtask
  task automatic s_rx7();
    apb(1'b1, OFS_CTRL, {28'h000_0003, MODE_S7});
    x(OP_START);
    apb(1'b1, OFS_IRQ, 32'h0000_0000);
    xw(8'hA4, 1'b0);
    rc("irq", OFS_IRQ, 8'h01, 8'h01);
    apb(1'b1, OFS_IRQ, 32'h0000_0000);
    rc("irq clr", OFS_IRQ, 8'h01, 8'h00);
    rc("stat", OFS_STAT, 8'h07, 8'h01);
    rc("buf", OFS_BUF, 8'hFF, 8'hA4);
    rc("full clr", OFS_STAT, 8'h01, 8'h00);
    xw(8'h5A, 1'b0);
    apb(1'b1, OFS_IRQ, 32'h0000_0000);
    xw(8'h3C, 1'b1);
    rc("full irq", OFS_IRQ, 8'h01, 8'h01);
    rc("ovf", OFS_CTRL, 8'h40, 8'h40);
    rc("kept", OFS_BUF, 8'hFF, 8'h5A);
    rc("ovf held", OFS_CTRL, 8'h40, 8'h40);
    apb(1'b1, OFS_CTRL, {28'h000_0003, MODE_S7});
    rc("ovf clr", OFS_CTRL, 8'h40, 8'h00);
    x(OP_STOP);
    x(OP_START);
    xw(8'hA5, 1'b0);
    rc("rd stat", OFS_STAT, 8'h07, 8'h05);
    rc("rd buf", OFS_BUF, 8'hFF, 8'hA5);
    rdbyte(8'hC3, MODE_S7);
    x(OP_STOP);
  endtask
  task automatic s_ten();
    apb(1'b1, OFS_CTRL, {28'h000_0003, MODE_S10});
    apb(1'b1, OFS_ADDR, 32'h0000_00F4);
    x(OP_START);
    xw({TEN_HDR, 2'b10, 1'b0}, 1'b0);
    rc("hi stat", OFS_STAT, 8'h07, 8'h03);
    rc("hi buf", OFS_BUF, 8'hFF, 8'hF4);
    apb(1'b1, OFS_ADDR, 32'h0000_00B5);
    rc("upd clr", OFS_STAT, 8'h02, 8'h00);
    xw(8'hB5, 1'b0);
    rc("lo stat", OFS_STAT, 8'h07, 8'h03);
    rc("lo buf", OFS_BUF, 8'hFF, 8'hB5);
    apb(1'b1, OFS_ADDR, 32'h0000_00F4);
    xw(8'h77, 1'b0);
    rc("data", OFS_BUF, 8'hFF, 8'h77);
    x(OP_START);
    xw(8'hF5, 1'b0);
    rc("re stat", OFS_STAT, 8'h07, 8'h05);
    rc("re buf", OFS_BUF, 8'hFF, 8'hF5);
    rdbyte(8'h96, MODE_S10);
    x(OP_STOP);
  endtask
  // ==========================================================
  // Verdict, watchdog and main sequence
  task automatic conclude();
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    #2_000_000;
    failures++;
    conclude();
  end
  // Reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_off();
    s_modes();
    s_rx7();
    s_ten();
    conclude();
  end
endmodule
`default_nettype wire
